// *** artr_top.sv ***
// Auto-reload timer: register file on Avalon-MM plus counter, prescaler and PWM
//
// Functional notes
// (RULE1) Load trigger copies reload, clears prescaler; reads zero
// (RULE2) Count enable runs counter; clear freezes both
// (RULE3) Pulse pin carries PWM only when enabled
// (RULE4) Edge flag with enable raises interrupt
// (RULE5) Match flag with enable raises interrupt
// (RULE6) Rollover flag with enable raises interrupt
// (RULE7) Mode field selects reload/capture/capture-reset/ext-load
// (RULE8) Reset clears mode register; readable and writable
// (RULE9) Flags read normally; write zero clears
// (RULE10) Active input edge sets edge flag
// (RULE11) Counter equal compare sets match flag
// (RULE12) Counter FFh to 00h sets rollover flag
// (RULE13) Prescaler ratio is two to field
// (RULE14) Prescaler select changes tap only
// (RULE15) Edge enable bit and polarity bit
// (RULE16) Clock source: internal, divided by three, pin
// (RULE17) Live register accesses counter while counting
// (RULE18) Load register keeps contents through reset
// (RULE19) Overflow reloads counter from reload register
// (RULE20) Compare register holds match value
// (RULE21) Overflow drives pulse high, match drives low
// (RULE22) Capture modes copy counter on input edge
// (RULE23) Capture-reset also clears counter and prescaler
// (RULE24) External-load mode loads counter on edge
// (RULE25) Masked requests ORed into one interrupt
`timescale 1ns/100ps
`default_nettype none

module artr_top (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [artr_pkg::ARTR_ADDR_W-1:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [artr_pkg::ARTR_DATA_W-1:0] writedata_i,
  input wire logic [artr_pkg::ARTR_BE_W-1:0] byteenable_i,
  output logic [artr_pkg::ARTR_DATA_W-1:0] readdata_o,
  output logic waitrequest_o,
  input wire logic timer_input_pin_i,
  output logic pulse_output_pin_o,
  output logic timer_irq_o
);
  import artr_pkg::*;

  artr_state_t st_ff;
  artr_state_t nxt_st;

  logic [7:0] idx;
  logic acc;
  logic wr_go;
  logic [7:0] wbyte;
  logic wr_mode;
  logic wr_flag;
  logic wr_cfg;
  logic wr_reload;
  logic wr_cmp;
  logic wr_live;
  logic [1:0] mode;
  logic count_en;
  logic [2:0] ps_sel;
  logic [1:0] cs_sel;
  logic [6:0] ps_mask;
  logic stable_lvl;
  logic rise;
  logic fall;
  logic edge_evt;
  logic src_tick;
  logic tick;
  logic roll;
  logic match;
  logic [7:0] cnt_inc;
  logic [2:0] flag_set;
  logic [7:0] rd_byte;

  assign idx = address_i[9:2];
  assign acc = read_i | write_i;
  // One wait state: the answer is registered, so readdata comes from a flop
  assign waitrequest_o = acc & ~st_ff.ack;
  assign wr_go = write_i & st_ff.ack & byteenable_i[0];
  assign wbyte = writedata_i[7:0];
  assign wr_mode = wr_go & (idx == ARTR_IDX_MODE);
  assign wr_flag = wr_go & (idx == ARTR_IDX_FLAG);
  assign wr_cfg = wr_go & (idx == ARTR_IDX_CFG);
  assign wr_reload = wr_go & (idx == ARTR_IDX_RELOAD);
  assign wr_cmp = wr_go & (idx == ARTR_IDX_CMP);
  assign wr_live = wr_go & (idx == ARTR_IDX_LIVE);

  assign mode = st_ff.mode_ctl[ARTR_MC_MODE_LSB +: 2];
  assign count_en = st_ff.mode_ctl[ARTR_MC_COUNT_EN];
  assign ps_sel = st_ff.cfg[ARTR_CF_PS_LSB +: 3];
  assign cs_sel = st_ff.cfg[ARTR_CF_CS_LSB +: 2];

  // Pin level accepted only once the last two sync stages agree
  assign stable_lvl = (st_ff.pin_sync[1] == st_ff.pin_sync[2]) ?
                      st_ff.pin_sync[2] : st_ff.pin_lvl;
  assign rise = stable_lvl & ~st_ff.pin_lvl;
  assign fall = ~stable_lvl & st_ff.pin_lvl;
  assign edge_evt = st_ff.cfg[ARTR_CF_EDGE_EN] &
                    (st_ff.cfg[ARTR_CF_EDGE_POL] ? fall : rise); // RULE15

  // Source tick, before the prescaler
  always_comb begin
    unique case (cs_sel)
      ARTR_CS_INT: src_tick = 1'b1; // RULE16
      ARTR_CS_INT_DIV3: src_tick = (st_ff.div3 == ARTR_DIV3_LAST); // RULE16
      ARTR_CS_PIN: src_tick = rise; // RULE16
      default: src_tick = 1'b0;
    endcase
  end

  // Tap select only; the prescaler count itself is never touched here
  assign ps_mask = 7'((8'h01 << ps_sel) - 8'h01); // RULE13 RULE14
  assign tick = count_en & src_tick & ((st_ff.psc & ps_mask) == ps_mask); // RULE2
  assign roll = tick & (st_ff.cnt == ARTR_CNT_MAX); // RULE12
  assign cnt_inc = st_ff.cnt + 8'h01;
  assign match = tick & ~roll & (cnt_inc == st_ff.compare); // RULE11 RULE20

  always_comb begin
    flag_set = 3'h0;
    flag_set[ARTR_FL_EDGE] = edge_evt; // RULE10
    flag_set[ARTR_FL_MATCH] = match; // RULE11
    flag_set[ARTR_FL_ROLL] = roll; // RULE12
  end

  // Read mux; trigger bit and unused bits other than config bit 4 read as zero
  always_comb begin
    unique case (idx)
      ARTR_IDX_MODE: rd_byte = {1'b0, st_ff.mode_ctl}; // RULE1 RULE8
      ARTR_IDX_FLAG: rd_byte = {5'h00, st_ff.flags}; // RULE9
      ARTR_IDX_CFG: rd_byte = st_ff.cfg;
      ARTR_IDX_RELOAD: rd_byte = st_ff.reload;
      ARTR_IDX_CMP: rd_byte = st_ff.compare;
      ARTR_IDX_LIVE: rd_byte = st_ff.cnt; // RULE17
      default: rd_byte = 8'h00;
    endcase
  end

  always_comb begin
    nxt_st = st_ff;

    // Bus handshake
    nxt_st.ack = acc & ~st_ff.ack;
    if (acc & ~st_ff.ack) begin
      nxt_st.rdata = {24'h000000, rd_byte};
    end

    // Synchroniser and accepted pin level
    nxt_st.pin_sync = {st_ff.pin_sync[1:0], timer_input_pin_i};
    nxt_st.pin_lvl = stable_lvl;

    // Divide-by-three source, frozen with the counter
    if (count_en & (cs_sel == ARTR_CS_INT_DIV3)) begin
      if (st_ff.div3 == ARTR_DIV3_LAST) begin
        nxt_st.div3 = 2'h0;
      end else begin
        nxt_st.div3 = st_ff.div3 + 2'h1;
      end
    end

    // Register writes
    if (wr_mode) begin
      nxt_st.mode_ctl = wbyte[6:0]; // RULE8
    end
    if (wr_cfg) begin
      nxt_st.cfg = wbyte; // RULE14
    end
    if (wr_cmp) begin
      nxt_st.compare = wbyte; // RULE20
    end
    if (wr_reload) begin
      nxt_st.reload = wbyte;
    end
    if (wr_live) begin
      nxt_st.load = wbyte; // RULE17
    end

    // Prescaler and counter; software loads take priority over edges and ticks
    if (count_en & src_tick) begin
      nxt_st.psc = st_ff.psc + 7'h01; // RULE2
    end
    if (tick) begin
      if (roll) begin
        nxt_st.cnt = st_ff.reload; // RULE19
      end else begin
        nxt_st.cnt = cnt_inc;
      end
    end

    if (edge_evt) begin
      unique case (mode)
        ARTR_MODE_CAPT: begin
          nxt_st.reload = st_ff.cnt; // RULE7 RULE22
        end
        ARTR_MODE_CAPT_RST: begin
          nxt_st.reload = st_ff.cnt; // RULE22
          nxt_st.cnt = 8'h00; // RULE23
          nxt_st.psc = 7'h00; // RULE23
        end
        ARTR_MODE_EXT_LOAD: begin
          nxt_st.cnt = st_ff.reload; // RULE24
          nxt_st.psc = 7'h00; // RULE24
        end
        ARTR_MODE_RELOAD: begin
        end
      endcase
    end

    if (wr_mode & wbyte[ARTR_MC_LOAD_TRIG]) begin
      nxt_st.cnt = st_ff.reload; // RULE1
      nxt_st.psc = 7'h00; // RULE1
    end
    if (wr_live) begin
      nxt_st.cnt = wbyte; // RULE17
      nxt_st.psc = 7'h00;
    end

    // PWM: match pulls low after an overflow set it high
    if (match) begin
      nxt_st.pwm = 1'b0; // RULE21
    end else if (roll) begin
      nxt_st.pwm = 1'b1; // RULE21
    end

    // Flags: a hardware set in the same cycle beats a software clear
    if (wr_flag) begin
      nxt_st.flags = st_ff.flags & wbyte[2:0]; // RULE9
    end
    nxt_st.flags = nxt_st.flags | flag_set; // RULE10 RULE11 RULE12
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_ff.mode_ctl <= ARTR_RST_MODE; // RULE8
      st_ff.cfg <= ARTR_RST_CFG;
      st_ff.flags <= ARTR_RST_FLAGS;
      st_ff.reload <= ARTR_RST_BYTE;
      st_ff.compare <= ARTR_RST_BYTE;
      st_ff.load <= st_ff.load; // RULE18
      st_ff.cnt <= ARTR_RST_BYTE;
      st_ff.psc <= 7'h00;
      st_ff.div3 <= 2'h0;
      st_ff.pin_sync <= 3'h0;
      st_ff.pin_lvl <= 1'b0;
      st_ff.pwm <= 1'b0;
      st_ff.ack <= 1'b0;
      st_ff.rdata <= 32'h00000000;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign readdata_o = st_ff.rdata;
  assign pulse_output_pin_o = st_ff.mode_ctl[ARTR_MC_PULSE_OE] & st_ff.pwm; // RULE3
  assign timer_irq_o =
    (st_ff.mode_ctl[ARTR_MC_EDGE_IE] & st_ff.flags[ARTR_FL_EDGE]) | // RULE4 RULE25
    (st_ff.mode_ctl[ARTR_MC_MATCH_IE] & st_ff.flags[ARTR_FL_MATCH]) | // RULE5
    (st_ff.mode_ctl[ARTR_MC_ROLL_IE] & st_ff.flags[ARTR_FL_ROLL]); // RULE6

endmodule

`default_nettype wire

// *** artr_pkg.sv ***
// Constants and types shared by the auto-reload timer register block
package artr_pkg;

  // Register indices; Avalon byte address is four times the index
  localparam logic [7:0] ARTR_IDX_MODE = 8'hd5;
  localparam logic [7:0] ARTR_IDX_FLAG = 8'hd6;
  localparam logic [7:0] ARTR_IDX_CFG = 8'hd7;
  localparam logic [7:0] ARTR_IDX_RELOAD = 8'hd9;
  localparam logic [7:0] ARTR_IDX_CMP = 8'hda;
  localparam logic [7:0] ARTR_IDX_LIVE = 8'hdb;

  localparam int ARTR_ADDR_W = 10;
  localparam int ARTR_DATA_W = 32;
  localparam int ARTR_BE_W = 4;

  // Mode control register fields
  localparam int ARTR_MC_LOAD_TRIG = 7;
  localparam int ARTR_MC_COUNT_EN = 6;
  localparam int ARTR_MC_PULSE_OE = 5;
  localparam int ARTR_MC_EDGE_IE = 4;
  localparam int ARTR_MC_MATCH_IE = 3;
  localparam int ARTR_MC_ROLL_IE = 2;
  localparam int ARTR_MC_MODE_LSB = 0;

  // Flag register fields
  localparam int ARTR_FL_EDGE = 2;
  localparam int ARTR_FL_MATCH = 1;
  localparam int ARTR_FL_ROLL = 0;

  // Clock/edge configuration register fields
  localparam int ARTR_CF_PS_LSB = 5;
  localparam int ARTR_CF_EDGE_POL = 3;
  localparam int ARTR_CF_EDGE_EN = 2;
  localparam int ARTR_CF_CS_LSB = 0;

  localparam logic [1:0] ARTR_MODE_RELOAD = 2'h0;
  localparam logic [1:0] ARTR_MODE_CAPT = 2'h1;
  localparam logic [1:0] ARTR_MODE_CAPT_RST = 2'h2;
  localparam logic [1:0] ARTR_MODE_EXT_LOAD = 2'h3;

  localparam logic [1:0] ARTR_CS_INT = 2'h0;
  localparam logic [1:0] ARTR_CS_INT_DIV3 = 2'h1;
  localparam logic [1:0] ARTR_CS_PIN = 2'h2;

  // Reset values, counter maximum and last divide-by-three count
  localparam logic [6:0] ARTR_RST_MODE = 7'h00;
  localparam logic [7:0] ARTR_RST_CFG = 8'h00;
  localparam logic [2:0] ARTR_RST_FLAGS = 3'h0;
  localparam logic [7:0] ARTR_RST_BYTE = 8'h00;
  localparam logic [7:0] ARTR_CNT_MAX = 8'hff;
  localparam logic [1:0] ARTR_DIV3_LAST = 2'h2;

  typedef struct packed {
    logic [6:0] mode_ctl;
    logic [7:0] cfg;
    logic [2:0] flags;
    logic [7:0] reload;
    logic [7:0] compare;
    logic [7:0] load;
    logic [7:0] cnt;
    logic [6:0] psc;
    logic [1:0] div3;
    logic [2:0] pin_sync;
    logic pin_lvl;
    logic pwm;
    logic ack;
    logic [31:0] rdata;
  } artr_state_t;

endpackage

// *** artr_host.sv ***
// Avalon-MM master model standing in for the processor core
`timescale 1ns/100ps
`default_nettype none
module artr_host (
  input wire logic clk_i,
  input wire logic waitrequest_i,
  input wire logic [31:0] readdata_i,
  output logic [9:0] address_o,
  output logic read_o,
  output logic write_o,
  output logic [31:0] writedata_o,
  output logic [3:0] byteenable_o
);
  initial begin
    {address_o, read_o, write_o, writedata_o, byteenable_o} = '0;
  end
  // Request stands until waitrequest is sampled low; sampled before the edge updates land
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                      input logic be, output logic [7:0] q);
    @(posedge clk_i);
    address_o <= {idx, 2'h0};
    read_o <= !wr;
    write_o <= wr;
    writedata_o <= {24'h0, d};
    byteenable_o <= {3'h0, be};
    @(posedge clk_i iff !waitrequest_i);
    q = readdata_i[7:0];
    read_o <= 1'b0;
    write_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** artr_props.sv ***
// Port-level assertions for the timer register block
`timescale 1ns/100ps
`default_nettype none
module artr_props
  import artr_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [ARTR_ADDR_W-1:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [ARTR_DATA_W-1:0] writedata_i,
  input wire logic [ARTR_BE_W-1:0] byteenable_i,
  input wire logic [ARTR_DATA_W-1:0] readdata_o,
  input wire logic waitrequest_o,
  input wire logic pulse_output_pin_o,
  input wire logic timer_irq_o
);
  wire logic req = read_i || write_i;
  wire logic acc = req && !waitrequest_o;
  wire logic mode_sel = address_i[9:2] == ARTR_IDX_MODE;
  wire logic wr_mode = acc && write_i && byteenable_i[0] && mode_sel;
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_wait_first: assert property (req && !$past(req) |-> waitrequest_o)
    else $error("first request cycle without wait");
  a_wait_once: assert property (req && waitrequest_o |=> !waitrequest_o)
    else $error("more than one wait state");
  a_idle_nowait: assert property (!req |-> !waitrequest_o)
    else $error("waitrequest while idle");
  a_reset_quiet: assert property ($past(reset_i) |-> !timer_irq_o && !pulse_output_pin_o)
    else $error("outputs active after reset");
  a_read_upper: assert property (acc && read_i |-> readdata_o[31:8] == 24'h0)
    else $error("upper read lanes not zero");
  a_trig_zero: assert property (acc && read_i && mode_sel |-> !readdata_o[ARTR_MC_LOAD_TRIG])
    else $error("load trigger reads one");
  a_pulse_off: assert property (wr_mode && !writedata_i[ARTR_MC_PULSE_OE] |=> !pulse_output_pin_o)
    else $error("pulse pin active while disabled");
  a_irq_mask: assert property (wr_mode && writedata_i[4:2] == 3'h0 |=> !timer_irq_o)
    else $error("interrupt while all masked");
  c_read: cover property (acc && read_i);
  c_irq: cover property (timer_irq_o);
  c_pulse: cover property (pulse_output_pin_o);
endmodule
bind artr_top artr_props i_props (.clk_i, .reset_i, .address_i, .read_i, .write_i, .writedata_i,
  .byteenable_i, .readdata_o, .waitrequest_o, .pulse_output_pin_o, .timer_irq_o);
`default_nettype wire

// *** artr_top_bench.sv ***
// Self-checking bench for the timer register block
`timescale 1ns/100ps
`default_nettype none
module artr_top_bench;
  import artr_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic pin = 1'b0;
  logic [9:0] address;
  logic rd, wr, wait_o, pulse, irq;
  logic [31:0] wdata, rdata;
  logic [3:0] be;
  int bad_count = 0;
  int n_tests = 0;
  int cycles = 0;
  int n, m;
  logic [15:0] lfsr = 16'h8a31;
  logic [7:0] mc, cf, rl, cp, cnt, q, nx, md;
  logic [7:0] fl = 8'h0;
  logic pwm = 1'b0;
  logic [7:0] idx_t[7] = '{8'hd5, 8'hd6, 8'hd7, 8'hd9, 8'hda, 8'hdb, 8'hd8};
  logic [7:0] cf_t[6] = '{8'h01, 8'h00, 8'h20, 8'h60, 8'he0, 8'h03};
  logic [7:0] ed_t[5] = '{8'h04, 8'h04, 8'h0c, 8'h04, 8'h08};
  artr_top i_dut (.clk_i(clk_i), .reset_i(reset_i), .address_i(address), .read_i(rd),
    .write_i(wr), .writedata_i(wdata), .byteenable_i(be), .readdata_o(rdata),
    .waitrequest_o(wait_o), .timer_input_pin_i(pin), .pulse_output_pin_o(pulse),
    .timer_irq_o(irq));
  artr_host i_host (.clk_i(clk_i), .waitrequest_i(wait_o), .readdata_i(rdata),
    .address_o(address), .read_o(rd), .write_o(wr), .writedata_o(wdata), .byteenable_o(be));
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic w(input logic [7:0] idx, input logic [7:0] d);
    i_host.xfer(1'b1, idx, d, 1'b1, q);
  endtask
  task automatic r(input logic [7:0] idx, input string what, input logic [7:0] exp);
    i_host.xfer(1'b0, idx, 8'h0, 1'b1, q);
    chk(what, q, exp);
  endtask
  // One counter step of the reference model
  task automatic tick();
    nx = (cnt == 8'hff) ? rl : cnt + 8'h1;
    if (cnt == 8'hff) begin
      fl = fl | 8'h1;
      pwm = 1'b1;
    end
    if (nx == cp) begin
      fl = fl | 8'h2;
      pwm = 1'b0;
    end
    cnt = nx;
  endtask
  initial begin
    forever #20 clk_i = !clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      close_out();
    end
  end
  initial begin
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    foreach (idx_t[i]) r(idx_t[i], "reset value", 8'h0);
    w(8'hd8, rnd());
    r(8'hd8, "unmapped", 8'h0);
    i_host.xfer(1'b1, ARTR_IDX_RELOAD, 8'h5a, 1'b0, q);
    r(ARTR_IDX_RELOAD, "lane off write", 8'h0);
    rl = rnd();
    w(ARTR_IDX_RELOAD, rl);
    w(ARTR_IDX_MODE, 8'h80);
    r(ARTR_IDX_MODE, "trigger bit", 8'h0);
    r(ARTR_IDX_LIVE, "triggered load", rl);
    cnt = rl;
    // Stop-start windows; divided clock first while its phase is still known
    foreach (cf_t[i]) begin
      cf = cf_t[i];
      w(ARTR_IDX_CFG, cf);
      rl = rnd() & 8'h7f;
      cp = 8'h80 | (rnd() & 8'h6f);
      cnt = 8'hf0 | (rnd() & 8'h0f);
      mc = 8'h40 | (rnd() & 8'h3c);
      n = 200 + int'(rnd());
      w(ARTR_IDX_RELOAD, rl);
      w(ARTR_IDX_CMP, cp);
      w(ARTR_IDX_LIVE, cnt);
      w(ARTR_IDX_MODE, mc);
      repeat (n) @(posedge clk_i);
      mc = mc & 8'h3c;
      w(ARTR_IDX_MODE, mc);
      m = (cf[1:0] == 2'h0) ? n + 3 : (cf[1:0] == 2'h1) ? (n + 3) / 3 : 0;
      repeat (m >> cf[7:5]) tick();
      r(ARTR_IDX_LIVE, "counter", cnt);
      r(ARTR_IDX_LIVE, "frozen", cnt);
      r(ARTR_IDX_CMP, "compare", cp);
      r(ARTR_IDX_FLAG, "flags", fl);
      r(ARTR_IDX_MODE, "mode", mc);
      chk("pulse", {7'h0, pulse}, {7'h0, mc[5] & pwm});
      chk("irq", {7'h0, irq}, {7'h0, |(fl[2:0] & mc[4:2])});
      q = rnd() & 8'h07;
      fl = fl & q;
      w(ARTR_IDX_FLAG, q);
      r(ARTR_IDX_FLAG, "flag clear", fl);
    end
    // Input edges in each mode, counter stopped
    foreach (ed_t[i]) begin
      cf = ed_t[i];
      md = (i == 4) ? 8'h1 : 8'(i);
      mc = md | 8'h10;
      cnt = 8'hf0 | (rnd() & 8'h0f);
      rl = rnd() & 8'h7f;
      w(ARTR_IDX_CFG, cf);
      w(ARTR_IDX_MODE, mc);
      w(ARTR_IDX_RELOAD, rl);
      w(ARTR_IDX_LIVE, cnt);
      fl = 8'h0;
      w(ARTR_IDX_FLAG, 8'h0);
      pin <= 1'b1;
      repeat (6) @(posedge clk_i);
      pin <= 1'b0;
      repeat (6) @(posedge clk_i);
      if (cf[2]) begin
        fl = 8'h4;
        if (md == 8'h1 || md == 8'h2) rl = cnt;
        if (md == 8'h2) cnt = 8'h0;
        if (md == 8'h3) cnt = rl;
      end
      r(ARTR_IDX_FLAG, "edge flag", fl);
      r(ARTR_IDX_RELOAD, "capture", rl);
      r(ARTR_IDX_LIVE, "edge counter", cnt);
      chk("edge irq", {7'h0, irq}, {7'h0, fl[2]});
    end
    close_out();
  end
endmodule
`default_nettype wire
